/* File: hdl/adcslm_rx.sv */
/*
 Receive end: unpacks lane frames back into channel samples.
 Assumes the transmit end runs on the same clk_sys with the same CHANNELS.
 Samples come out left-justified in 12 bits, low bits zero when narrower.
*/
`timescale 1ns/1ps
`default_nettype none

module adcslm_rx #(
  parameter int CHANNELS = 4
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  adcslm_link_if.rx                         link,
  output logic                              smp_valid_r,
  output adcslm_pkg::adcslm_blk_t           smp_r,
  output logic [adcslm_pkg::FMT_W-1:0]      fmt_r,
  output logic                              frame_err_r
);

  if (CHANNELS != 1 && CHANNELS != 2 && CHANNELS != 4) begin : g_chk
    $error("CHANNELS must be 1, 2 or 4");
  end

  localparam int LW = adcslm_pkg::LANE_W;

  adcslm_pkg::adcslm_lanes_t    ln;
  adcslm_pkg::adcslm_blk_t      smp_nxt;
  logic [adcslm_pkg::LANES-1:0] on_exp;
  logic                         err_nxt;
  int                           used;
  int                           bits;

  ////////////////////////////////////////////////////////////////////////
  // Inverse of the transmit mapping

  always_comb begin
    ln      = link.lane_data;
    smp_nxt = '0;
    case (link.link_format_select)
      adcslm_pkg::FMT_M1, adcslm_pkg::FMT_M6: begin
        smp_nxt[0][0] = ln[0][LW-1 -: 12];
        smp_nxt[0][1] = {ln[0][LW-13 -: 4], ln[1][LW-1 -: 8]};
        smp_nxt[1][0] = {ln[1][LW-9 -: 8], ln[2][LW-1 -: 4]};
        smp_nxt[1][1] = ln[2][LW-5 -: 12];
        smp_nxt[2][0] = ln[3][LW-1 -: 12];
        smp_nxt[2][1] = {ln[3][LW-13 -: 4], ln[4][LW-1 -: 8]};
        smp_nxt[3][0] = {ln[4][LW-9 -: 8], ln[5][LW-1 -: 4]};
        smp_nxt[3][1] = ln[5][LW-5 -: 12];
      end
      adcslm_pkg::FMT_M2, adcslm_pkg::FMT_M7: begin
        for (int c = 0; c < adcslm_pkg::CHANS; c++) begin
          smp_nxt[c][0] = {ln[c][LW-1 -: 8], adcslm_pkg::PAD4};
        end
      end
      adcslm_pkg::FMT_M3: begin
        for (int c = 0; c < adcslm_pkg::CHANS; c++) begin
          for (int i = 0; i < adcslm_pkg::SPF; i++) begin
            smp_nxt[c][i] = {ln[c][LW-1-10*i -: 10], adcslm_pkg::PAD2};
          end
        end
      end
      adcslm_pkg::FMT_M4: begin
        smp_nxt[0][0] = ln[0][LW-1 -: 12];
        smp_nxt[1][0] = {ln[0][LW-13 -: 4], ln[1][LW-1 -: 8]};
        smp_nxt[2][0] = {ln[1][LW-9 -: 8], ln[2][LW-1 -: 4]};
        smp_nxt[3][0] = ln[2][LW-5 -: 12];
      end
      adcslm_pkg::FMT_M5: begin
        smp_nxt[0][0] = {ln[0][LW-1 -: 8], adcslm_pkg::PAD4};
        smp_nxt[1][0] = {ln[0][LW-9 -: 8], adcslm_pkg::PAD4};
        smp_nxt[2][0] = {ln[1][LW-1 -: 8], adcslm_pkg::PAD4};
        smp_nxt[3][0] = {ln[1][LW-9 -: 8], adcslm_pkg::PAD4};
      end
      default: begin
        smp_nxt = '0;
      end
    endcase
    for (int c = 0; c < adcslm_pkg::CHANS; c++) begin
      if (c >= CHANNELS) begin
        smp_nxt[c] = '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Lane enables and tail bits checked against the agreed layout

  always_comb begin
    used    = adcslm_pkg::lane_count(link.link_format_select, CHANNELS);
    bits    = adcslm_pkg::OCT_W * int'(link.frame_octets);
    err_nxt = (used == 0) ||
              (link.frame_octets !=
               adcslm_pkg::frame_octets(link.link_format_select));
    for (int l = 0; l < adcslm_pkg::LANES; l++) begin
      on_exp[l] = (l < used);
      for (int b = 0; b < LW; b++) begin
        // Nonzero bits past the frame or on an idle lane are a fault
        if ((b < LW - bits || l >= used) && ln[l][b]) begin
          err_nxt = 1'b1;
        end
      end
    end
    if (on_exp != link.lane_on) begin
      err_nxt = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output registers

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      smp_valid_r <= 1'b0;
      frame_err_r <= 1'b0;
    end else begin
      smp_valid_r <= link.frame_valid;
      frame_err_r <= link.frame_valid && err_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      smp_r <= '0;
      fmt_r <= '0;
    end else if (link.frame_valid) begin
      smp_r <= smp_nxt;
      fmt_r <= link.link_format_select;
    end
  end

endmodule : adcslm_rx

`default_nettype wire

/* File: inc/adcslm_pkg.sv */
/*
 Shared constants, types and lane-count helpers for the sample lane mapper.
 Assumes both link ends are compiled against this package.
*/
`default_nettype none

package adcslm_pkg;

  localparam int LANES     = 6;   // Most lanes any format uses
  localparam int CHANS     = 4;   // Channels A to D
  localparam int SPF       = 4;   // Sample slots per channel per frame
  localparam int SMP_W     = 12;  // Sample width, left-justified
  localparam int OCT_W     = 8;
  localparam int MAX_OCT   = 5;
  localparam int LANE_W    = OCT_W * MAX_OCT;
  localparam int FMT_W     = 3;
  localparam int OCT_CNT_W = 3;

  // Link format codes
  localparam logic [FMT_W-1:0] FMT_M1 = 3'h1;
  localparam logic [FMT_W-1:0] FMT_M2 = 3'h2;
  localparam logic [FMT_W-1:0] FMT_M3 = 3'h3;
  localparam logic [FMT_W-1:0] FMT_M4 = 3'h4;
  localparam logic [FMT_W-1:0] FMT_M5 = 3'h5;
  localparam logic [FMT_W-1:0] FMT_M6 = 3'h6;
  localparam logic [FMT_W-1:0] FMT_M7 = 3'h7;

  // Padding fills for narrow samples
  localparam logic [3:0] PAD4 = 4'h0;
  localparam logic [1:0] PAD2 = 2'h0;

  typedef logic [SMP_W-1:0]                     adcslm_smp_t;
  typedef adcslm_smp_t [CHANS-1:0][SPF-1:0]     adcslm_blk_t;
  typedef logic [LANES-1:0][LANE_W-1:0]         adcslm_lanes_t;

  // Lanes in use, counted from lane 0
  function automatic int lane_count(logic [FMT_W-1:0] fmt, int ch);
    case (fmt)
      FMT_M1, FMT_M6: lane_count = (ch == 4) ? 6 : (ch == 2) ? 3 : 2;
      FMT_M2, FMT_M3,
      FMT_M7:         lane_count = (ch == 4) ? 4 : (ch == 2) ? 2 : 1;
      FMT_M4:         lane_count = (ch == 4) ? 3 : (ch == 2) ? 2 : 1;
      FMT_M5:         lane_count = (ch == 4) ? 2 : 1;
      default:        lane_count = 0;
    endcase
  endfunction

  // Octets per lane frame
  function automatic logic [OCT_CNT_W-1:0] frame_octets(
      logic [FMT_W-1:0] fmt);
    case (fmt)
      FMT_M2, FMT_M7: frame_octets = 3'h1;
      FMT_M3:         frame_octets = 3'h5;
      FMT_M1, FMT_M4,
      FMT_M5, FMT_M6: frame_octets = 3'h2;
      default:        frame_octets = 3'h0;
    endcase
  endfunction

endpackage : adcslm_pkg

`default_nettype wire

/* File: inc/adcslm_link_if.sv */
/*
 Lane bundle between the mapper (transmit) and the unpacker (receive).
 Assumes both ends share clk_sys; octet 0 sits in the top bits of a lane.
*/
`timescale 1ns/1ps
`default_nettype none

interface adcslm_link_if;
  logic                                 frame_valid;
  logic [adcslm_pkg::FMT_W-1:0]         link_format_select;
  logic [adcslm_pkg::OCT_CNT_W-1:0]     frame_octets;
  logic [adcslm_pkg::LANES-1:0]         lane_on;
  adcslm_pkg::adcslm_lanes_t            lane_data;

  modport tx (
    output frame_valid,
    output link_format_select,
    output frame_octets,
    output lane_on,
    output lane_data
  );

  modport rx (
    input  frame_valid,
    input  link_format_select,
    input  frame_octets,
    input  lane_on,
    input  lane_data
  );
endinterface : adcslm_link_if

`default_nettype wire

/* File: hdl/adcslm_tx.sv */
/*
 Transmit end: packs one frame of channel samples into lane frames.
 Assumes samples are left-justified 12-bit words; narrower formats keep
 the upper bits. One frame per cycle, no back-pressure on the link.
*/
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Format 1: 12-bit two-octet lanes, six max
// - Format 2: one 8-bit sample per lane
// - Format 3: four 10-bit samples, five octets
// - Format 4: 12-bit A-D packed over three lanes
// - Format 5: two 8-bit samples per lane
// - Format 6: packed like format 1
// - Format 7: one 8-bit sample per lane
// - Tail and padding bits are zero
// - Samples placed MSB first
// - Lowest lanes used, others powered down
module adcslm_tx #(
  parameter int CHANNELS = 4
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  input  wire logic                         smp_valid,
  input  wire logic [adcslm_pkg::FMT_W-1:0] link_format_select,
  input  wire adcslm_pkg::adcslm_blk_t      smp,
  adcslm_link_if.tx                         link
);

  if (CHANNELS != 1 && CHANNELS != 2 && CHANNELS != 4) begin : g_chk
    $error("CHANNELS must be 1, 2 or 4");
  end

  localparam int LW = adcslm_pkg::LANE_W;
  localparam int OW = adcslm_pkg::OCT_W;

  adcslm_pkg::adcslm_blk_t   sm;
  adcslm_pkg::adcslm_lanes_t lanes_nxt;
  logic [adcslm_pkg::LANES-1:0] on_nxt;
  int                        used;

  ////////////////////////////////////////////////////////////////////////
  // Absent channels read as zero, which supplies the 0x0/0x00 fills

  always_comb begin
    for (int c = 0; c < adcslm_pkg::CHANS; c++) begin
      sm[c] = (c < CHANNELS) ? smp[c] : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame mapping; octet 0 is the top byte of each lane word

  always_comb begin
    lanes_nxt = '0;
    case (link_format_select)
      adcslm_pkg::FMT_M1, adcslm_pkg::FMT_M6: begin
        lanes_nxt[0][LW-1 -: 2*OW] = {sm[0][0], sm[0][1][11:8]};
        lanes_nxt[1][LW-1 -: 2*OW] = {sm[0][1][7:0], sm[1][0][11:4]};
        lanes_nxt[2][LW-1 -: 2*OW] = {sm[1][0][3:0], sm[1][1]};
        lanes_nxt[3][LW-1 -: 2*OW] = {sm[2][0], sm[2][1][11:8]};
        lanes_nxt[4][LW-1 -: 2*OW] = {sm[2][1][7:0], sm[3][0][11:4]};
        lanes_nxt[5][LW-1 -: 2*OW] = {sm[3][0][3:0], sm[3][1]};
      end
      adcslm_pkg::FMT_M2, adcslm_pkg::FMT_M7: begin
        for (int c = 0; c < adcslm_pkg::CHANS; c++) begin
          lanes_nxt[c][LW-1 -: OW] = sm[c][0][11:4];
        end
      end
      adcslm_pkg::FMT_M3: begin
        for (int c = 0; c < adcslm_pkg::CHANS; c++) begin
          lanes_nxt[c] = {sm[c][0][11:2], sm[c][1][11:2],
                          sm[c][2][11:2], sm[c][3][11:2]};
        end
      end
      adcslm_pkg::FMT_M4: begin
        lanes_nxt[0][LW-1 -: 2*OW] = {sm[0][0], sm[1][0][11:8]};
        lanes_nxt[1][LW-1 -: 2*OW] = {sm[1][0][7:0], sm[2][0][11:4]};
        lanes_nxt[2][LW-1 -: 2*OW] = {sm[2][0][3:0], sm[3][0]};
      end
      adcslm_pkg::FMT_M5: begin
        lanes_nxt[0][LW-1 -: 2*OW] = {sm[0][0][11:4], sm[1][0][11:4]};
        lanes_nxt[1][LW-1 -: 2*OW] = {sm[2][0][11:4], sm[3][0][11:4]};
      end
      default: begin
        lanes_nxt = '0;
      end
    endcase
    used = adcslm_pkg::lane_count(link_format_select, CHANNELS);
    for (int l = 0; l < adcslm_pkg::LANES; l++) begin
      on_nxt[l] = (l < used);
      if (l >= used) begin
        lanes_nxt[l] = '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link registers

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      link.frame_valid        <= 1'b0;
      link.link_format_select <= '0;
      link.frame_octets       <= '0;
      link.lane_on            <= '0;
    end else begin
      link.frame_valid        <= smp_valid && (on_nxt != '0);
      link.link_format_select <= link_format_select;
      link.frame_octets       <= adcslm_pkg::frame_octets(link_format_select);
      link.lane_on            <= on_nxt;
    end
  end

  // Data holds while smp_valid is low so idle lanes do not toggle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      link.lane_data <= '0;
    end else if (smp_valid) begin
      link.lane_data <= lanes_nxt;
    end
  end

endmodule : adcslm_tx

`default_nettype wire

/* File: testbench/adcslm_link_sva.sv */
/*
 Assertions on the lane bundle between the mapper ends.
 Assumes one clk_sys domain and the same CHANNELS as both ends.
*/
`timescale 1ns/1ps
`default_nettype none

module adcslm_link_sva #(
  parameter int CHANNELS = 4
) (
  input wire logic                             clk_sys,
  input wire logic                             rst,
  input wire logic                             frame_valid,
  input wire logic [adcslm_pkg::FMT_W-1:0]     link_format_select,
  input wire logic [adcslm_pkg::OCT_CNT_W-1:0] frame_octets,
  input wire logic [adcslm_pkg::LANES-1:0]     lane_on,
  input wire adcslm_pkg::adcslm_lanes_t        lane_data
);
  logic        off_bad;
  logic        tail_bad;
  logic [39:0] tmask;

  function automatic int nl(logic [2:0] f);
    case (f)
      3'h1, 3'h6:       return (CHANNELS == 4) ? 6 : (CHANNELS == 2) ? 3 : 2;
      3'h2, 3'h3, 3'h7: return (CHANNELS == 4) ? 4 : (CHANNELS == 2) ? 2 : 1;
      3'h4:             return (CHANNELS == 4) ? 3 : (CHANNELS == 2) ? 2 : 1;
      3'h5:             return (CHANNELS == 4) ? 2 : 1;
      default:          return 0;
    endcase
  endfunction

  // Bits below the frame's last octet must stay clear
  always_comb begin
    off_bad = 1'b0;
    tail_bad = 1'b0;
    tmask = (40'h1 << (40 - 8 * int'(frame_octets))) - 40'h1;
    for (int l = 0; l < 6; l++) begin
      if (!lane_on[l] && lane_data[l] != '0) off_bad = 1'b1;
      if ((lane_data[l] & tmask) != '0) tail_bad = 1'b1;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_lanes; lane_on == (6'h3F >> (6 - nl(link_format_select)));
  endproperty
  a_lanes: assert property (p_lanes) else $error("lane_on count");
  property p_contig; (lane_on & (lane_on + 6'h01)) == 6'h00; endproperty
  a_contig: assert property (p_contig) else $error("lane gap");
  property p_oct; frame_octets == ((link_format_select == 3'h0) ? 3'h0 :
    (link_format_select == 3'h3) ? 3'h5 : (link_format_select == 3'h2 ||
    link_format_select == 3'h7) ? 3'h1 : 3'h2); endproperty
  a_oct: assert property (p_oct) else $error("frame_octets");
  property p_fmt0; link_format_select == 3'h0 |-> !frame_valid; endproperty
  a_fmt0: assert property (p_fmt0) else $error("frame on format 0");
  property p_off; frame_valid |-> !off_bad; endproperty
  a_off: assert property (p_off) else $error("off lane data");
  property p_tail; frame_valid |-> !tail_bad; endproperty
  a_tail: assert property (p_tail) else $error("tail bits set");
  property p_hold; !frame_valid && $changed(lane_data) |-> lane_data == '0;
  endproperty
  a_hold: assert property (p_hold) else $error("lane_data moved");
  property p_rst; $past(rst) |-> !frame_valid && lane_on == 6'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("busy after reset");
endmodule // adcslm_link_sva

`default_nettype wire

/* File: testbench/adc_sample_lane_mapper_test.sv */
/*
 Testbench: mapper and unpacker joined through the lane bundle.
 Assumes a quad part (CHANNELS 4) and a 50 ns clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module adc_sample_lane_mapper_test;
  typedef struct { logic [2:0] f; adcslm_pkg::adcslm_blk_t b; } adcslm_frm_t;
  localparam int NL[8] = '{0, 6, 4, 4, 3, 2, 6, 4};
  logic                    clk_sys, rst, smp_valid, smp_valid_r, frame_err_r;
  logic [2:0]              fmt, fmt_r;
  adcslm_pkg::adcslm_blk_t smp, smp_r;
  int                      n_fail = 0;
  int                      check_count = 0;
  adcslm_frm_t             q_tx[$], q_rx[$], it;

  adcslm_link_if adcslm_link_if_i ();
  adcslm_tx #(.CHANNELS(4)) adcslm_tx_i (.clk_sys(clk_sys), .rst(rst),
    .smp_valid(smp_valid), .link_format_select(fmt), .smp(smp),
    .link(adcslm_link_if_i));
  adcslm_rx #(.CHANNELS(4)) adcslm_rx_i (.clk_sys(clk_sys), .rst(rst),
    .link(adcslm_link_if_i), .smp_valid_r(smp_valid_r), .smp_r(smp_r),
    .fmt_r(fmt_r), .frame_err_r(frame_err_r));
  adcslm_link_sva #(.CHANNELS(4)) adcslm_link_sva_i (.clk_sys(clk_sys),
    .rst(rst), .frame_valid(adcslm_link_if_i.frame_valid),
    .link_format_select(adcslm_link_if_i.link_format_select),
    .frame_octets(adcslm_link_if_i.frame_octets),
    .lane_on(adcslm_link_if_i.lane_on), .lane_data(adcslm_link_if_i.lane_data));

  //////////////////////////////////////////////////////////////////////////////
  function automatic adcslm_pkg::adcslm_lanes_t exp_lanes(adcslm_frm_t x);
    adcslm_pkg::adcslm_lanes_t e;
    e = '0;
    case (x.f)
      3'h1, 3'h6: for (int k = 0; k < 2; k++) begin
        e[3*k] = {x.b[2*k][0], x.b[2*k][1][11:8], 24'h0};
        e[3*k+1] = {x.b[2*k][1][7:0], x.b[2*k+1][0][11:4], 24'h0};
        e[3*k+2] = {x.b[2*k+1][0][3:0], x.b[2*k+1][1], 24'h0};
      end
      3'h2, 3'h7: for (int c = 0; c < 4; c++) e[c] = {x.b[c][0][11:4], 32'h0};
      3'h3: for (int c = 0; c < 4; c++) e[c] = {x.b[c][0][11:2],
        x.b[c][1][11:2], x.b[c][2][11:2], x.b[c][3][11:2]};
      3'h4: begin
        e[0] = {x.b[0][0], x.b[1][0][11:8], 24'h0};
        e[1] = {x.b[1][0][7:0], x.b[2][0][11:4], 24'h0};
        e[2] = {x.b[2][0][3:0], x.b[3][0], 24'h0};
      end
      3'h5: begin
        e[0] = {x.b[0][0][11:4], x.b[1][0][11:4], 24'h0};
        e[1] = {x.b[2][0][11:4], x.b[3][0][11:4], 24'h0};
      end
      default: e = '0;
    endcase
    return e;
  endfunction

  // Narrow formats lose low bits and unused slots on the way through
  function automatic adcslm_pkg::adcslm_blk_t exp_smp(adcslm_frm_t x);
    adcslm_pkg::adcslm_blk_t e;
    logic [11:0]             m;
    int                      n;
    e = '0;
    m = 12'hFFF;
    n = (x.f == 3'h1 || x.f == 3'h6) ? 2 : (x.f == 3'h3) ? 4 : 1;
    if (x.f == 3'h3) m = 12'hFFC;
    if (x.f == 3'h2 || x.f == 3'h5 || x.f == 3'h7) m = 12'hFF0;
    for (int c = 0; c < 4; c++)
      for (int s = 0; s < n; s++) e[c][s] = x.b[c][s] & m;
    return e;
  endfunction

  task automatic chk(string nm, logic [239:0] e, logic [239:0] g);
    check_count++;
    if (e !== g) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic send(logic [2:0] f, logic [11:0] s);
    adcslm_pkg::adcslm_blk_t b;
    for (int c = 0; c < 4; c++)
      for (int k = 0; k < 4; k++) b[c][k] = s + 12'(c * 12'h351 + k * 12'h1C7);
    @(posedge clk_sys);
    smp_valid <= 1'b1;
    fmt <= f;
    smp <= b;
    if (f != 3'h0) q_tx.push_back('{f, b});
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  always @(negedge clk_sys) begin
    if (smp_valid_r) begin
      chk("rx queued", 240'h1, 240'(q_rx.size() > 0));
      if (q_rx.size() > 0) it = q_rx.pop_front();
      chk("smp_r", 240'(exp_smp(it)), 240'(smp_r));
      chk("fmt_r", 240'(it.f), 240'(fmt_r));
      chk("frame_err_r", 240'h0, 240'(frame_err_r));
    end
    if (adcslm_link_if_i.frame_valid) begin
      chk("tx queued", 240'h1, 240'(q_tx.size() > 0));
      if (q_tx.size() > 0) it = q_tx.pop_front();
      chk("lane_data", exp_lanes(it), adcslm_link_if_i.lane_data);
      chk("lane_on", 240'(6'h3F >> (6 - NL[it.f])), 240'(adcslm_link_if_i.lane_on));
      q_rx.push_back(it);
    end
  end

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (500) @(posedge clk_sys);
    n_fail++;
    test_done;
  end

  initial begin
    rst = 1'b1;
    smp_valid = 1'b0;
    fmt = 3'h0;
    smp = '0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    for (int r = 0; r < 2; r++)
      for (int f = 1; f < 8; f++) send(3'(f), 12'(f * 12'h2E9 + r * 12'hFFF));
    send(3'h0, 12'h5A5);
    send(3'h3, 12'hFFF);
    @(posedge clk_sys);
    smp_valid <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    send(3'h5, 12'h123);
    @(posedge clk_sys);
    smp_valid <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("frames left", 240'h0, 240'(q_tx.size() + q_rx.size()));
    test_done;
  end
endmodule // adc_sample_lane_mapper_test

`default_nettype wire
